// [rtl/sfe_device.sv]
// flash device end: erase, deep power-down and wake/id command handling
// Function
// - bits captured on serial clock rise, select low
// - 20H plus address wipes enclosing 4K sector
// - 52H plus address wipes enclosing 32K block
// - D8H plus address wipes enclosing 64K block
// - 60H or C7H wipes whole array
// - wipes refused unless write latch set
// - addressed wipe needs rise after 32nd bit
// - chip wipe, power-down need rise after 8th
// - busy flag high during self-timed wipe
// - status reads answered while busy
// - write latch cleared as wipe ends
// - addressed wipes of protected region not executed
// - chip wipe only with bp 0 uninverted or bp 7 inverted
// - B9H enters deep power after delay
// - deep power ignores all but wake, reset
// - power-down refused while cycle runs
// - plain deselect gives standby only
// - reset always starts in standby
// - wake ends deep power at once, standby after wake delay
// - AB plus three dummies shifts id out
// - id sent four times, then zeros until select rises
// - host waits longer delay after id wake
// - wake or id ignored while busy
`timescale 1ns/1ps
module sfe_device
   import sfe_pkg::*;
(
   // clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        ARST_N,
   input  wire logic        CE,
   // link
   sfe_link_if.device       LINK,
   // protection settings and device id
   input  wire logic [4:0]  PROT_RANGE,
   input  wire logic        PROT_INVERT,
   input  wire logic [7:0]  DEVICE_ID,
   // state
   output logic             BUSY,
   output logic             WRITE_LATCH,
   output logic             DEEP_POWER,
   output logic             WIPE_STROBE,
   output logic [23:0]      WIPE_ADDR,
   output logic [1:0]       WIPE_KIND
);
   typedef struct packed {
      logic        sck_p;
      logic        sel_p;
      logic [5:0]  bitcnt;
      logic [7:0]  op;
      logic [23:0] addr;
      logic [7:0]  sh;
      logic [7:0]  txsh;
      logic        miso;
      logic        oe_n;
      logic        busy;
      logic        write_latch_flag;
      logic [23:0] cnt;
      logic [23:0] pcnt;
      sfe_pwr_type pwr;
      logic        rst_en;
      logic        strobe;
      logic [23:0] waddr;
      logic [1:0]  wkind;
   } sfe_dev_type;
   sfe_dev_type r_q;
   sfe_dev_type r_d;
   logic sel_n_s;
   logic sck_s;
   logic mosi_s;
   sfe_sync u_sel (.clk(SYS_CLK), .arst_n(ARST_N), .ce(CE), .din(LINK.sel_n), .dout(sel_n_s));
   sfe_sync u_sck (.clk(SYS_CLK), .arst_n(ARST_N), .ce(CE), .din(LINK.sck), .dout(sck_s));
   sfe_sync u_si  (.clk(SYS_CLK), .arst_n(ARST_N), .ce(CE), .din(LINK.mosi), .dout(mosi_s));
   logic       rise;
   logic       fall;
   logic       sel_rise;
   logic [7:0] opn;
   logic       prot_hit;
   logic [4:0] bp;
   assign rise = sck_s & ~r_q.sck_p & ~sel_n_s;
   assign fall = ~sck_s & r_q.sck_p & ~sel_n_s;
   assign sel_rise = sel_n_s & ~r_q.sel_p;
   assign bp = PROT_RANGE;
   // simple upper-region protect: bp[2:0] nonzero protects top 64K * 2^(bp-1), PROT_INVERT protects the rest instead
   always_comb begin
      logic [7:0] top;
      top = 8'h00;
      if (bp[2:0] != 3'h0) begin
         top = 8'(8'hFF << (3'(bp[2:0]) - 3'h1));
      end
      prot_hit = (bp[2:0] != 3'h0) && ((r_q.addr[23:16] >= top) != PROT_INVERT);
   end
   always_comb begin
      r_d = r_q;
      opn = {r_q.op[6:0], mosi_s};
      if (CE) begin
         r_d.strobe = 1'b0;
         r_d.sck_p = sck_s;
         r_d.sel_p = sel_n_s;
         if (sel_n_s) begin
            r_d.bitcnt = 6'h00;
            r_d.oe_n = 1'b1;
         end
         if (rise) begin
            if (r_q.bitcnt < 6'h08) begin
               r_d.op = opn;
            end else if (r_q.bitcnt < 6'h20) begin
               r_d.addr = {r_q.addr[22:0], mosi_s};
            end
            if (r_q.bitcnt != 6'h3F) begin
               r_d.bitcnt = r_q.bitcnt + 6'h01;
            end
         end
         if (fall) begin
            if (r_q.op == OP_READ_STATUS && r_q.bitcnt >= 6'h08 && r_q.pwr != SFE_PWR_DEEP) begin
               r_d.oe_n = 1'b0;
               r_d.miso = (r_q.bitcnt[2:0] == 3'h7) ? r_q.busy : 1'b0;
               if (r_q.bitcnt[2:0] == 3'h6) begin
                  r_d.miso = r_q.write_latch_flag;
               end
            end else if (r_q.op == OP_WAKE_ID && r_q.bitcnt >= 6'h20 && !r_q.busy) begin
               r_d.oe_n = 1'b0;
               if (r_q.bitcnt[2:0] == 3'h0) begin
                  r_d.miso = DEVICE_ID[7];
                  r_d.txsh = {DEVICE_ID[6:0], 1'b0};
               end else begin
                  r_d.miso = r_q.txsh[7];
                  r_d.txsh = {r_q.txsh[6:0], 1'b0};
               end
            end
         end
         if (r_q.busy) begin
            if (r_q.cnt == 24'h000001) begin
               r_d.busy = 1'b0;
               r_d.write_latch_flag = 1'b0;
            end
            r_d.cnt = r_q.cnt - 24'h000001;
         end
         unique case (r_q.pwr)
            SFE_PWR_ENTER: begin
               r_d.pcnt = r_q.pcnt - 24'h000001;
               if (r_q.pcnt == 24'h000001) begin
                  r_d.pwr = SFE_PWR_DEEP;
               end
            end
            SFE_PWR_WAKING: begin
               r_d.pcnt = r_q.pcnt - 24'h000001;
               if (r_q.pcnt == 24'h000001) begin
                  r_d.pwr = SFE_PWR_STANDBY;
               end
            end
            SFE_PWR_STANDBY, SFE_PWR_DEEP: begin
            end
         endcase
         if (sel_rise) begin
            if (r_q.pwr == SFE_PWR_DEEP) begin
               if (r_q.bitcnt >= 6'h08 && r_q.op == OP_WAKE_ID) begin
                  r_d.pwr = SFE_PWR_WAKING;
                  r_d.pcnt = (r_q.bitcnt == 6'h08) ? WAKE_CYC : WAKE_ID_CYC;
               end else if (r_q.bitcnt == 6'h08 && r_q.op == OP_RESET_ENABLE) begin
                  r_d.rst_en = 1'b1;
               end else if (r_q.bitcnt == 6'h08 && r_q.op == OP_RESET && r_q.rst_en) begin
                  r_d.pwr = SFE_PWR_WAKING;
                  r_d.pcnt = WAKE_CYC;
                  r_d.rst_en = 1'b0;
               end
            end else if (r_q.pwr == SFE_PWR_STANDBY && !r_q.busy) begin
               r_d.rst_en = (r_q.bitcnt == 6'h08 && r_q.op == OP_RESET_ENABLE);
               if (r_q.bitcnt == 6'h08) begin
                  if (r_q.op == OP_WRITE_UNLOCK) begin
                     r_d.write_latch_flag = 1'b1;
                  end else if (r_q.op == OP_POWER_DOWN) begin
                     r_d.pwr = SFE_PWR_ENTER;
                     r_d.pcnt = PD_ENTRY_CYC;
                  end else if ((r_q.op == OP_CHIP_WIPE_A || r_q.op == OP_CHIP_WIPE_B)
                               && r_q.write_latch_flag
                               && ((bp[2:0] == 3'h0 && !PROT_INVERT)
                                   || (bp[2:0] == 3'h7 && PROT_INVERT))) begin
                     r_d.busy = 1'b1;
                     r_d.cnt = CHIP_WIPE_CYC;
                     r_d.strobe = 1'b1;
                     r_d.waddr = 24'h000000;
                     r_d.wkind = 2'h3;
                  end
               end else if (r_q.bitcnt == 6'h20 && r_q.write_latch_flag && !prot_hit) begin
                  r_d.strobe = 1'b1;
                  r_d.busy = 1'b1;
                  if (r_q.op == OP_SECTOR_WIPE) begin
                     r_d.cnt = SECTOR_WIPE_CYC;
                     r_d.waddr = {r_q.addr[23:12], 12'h000};
                     r_d.wkind = 2'h0;
                  end else if (r_q.op == OP_BLOCK32_WIPE) begin
                     r_d.cnt = BLOCK32_WIPE_CYC;
                     r_d.waddr = {r_q.addr[23:15], 15'h0000};
                     r_d.wkind = 2'h1;
                  end else if (r_q.op == OP_BLOCK64_WIPE) begin
                     r_d.cnt = BLOCK64_WIPE_CYC;
                     r_d.waddr = {r_q.addr[23:16], 16'h0000};
                     r_d.wkind = 2'h2;
                  end else begin
                     r_d.strobe = 1'b0;
                     r_d.busy = 1'b0;
                  end
               end
            end
         end
      end
   end
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         r_q <= '0;
         r_q.oe_n <= 1'b1;
         r_q.sel_p <= 1'b1;
         r_q.pwr <= SFE_PWR_STANDBY;
      end else begin
         r_q <= r_d;
      end
   end
   assign LINK.miso = r_q.miso;
   assign LINK.miso_oe_n = r_q.oe_n;
   assign BUSY = r_q.busy;
   assign WRITE_LATCH = r_q.write_latch_flag;
   assign DEEP_POWER = (r_q.pwr == SFE_PWR_DEEP);
   assign WIPE_STROBE = r_q.strobe;
   assign WIPE_ADDR = r_q.waddr;
   assign WIPE_KIND = r_q.wkind;
endmodule

// [pkg/sfe_pkg.sv]
// package: opcodes, timing counts, state types for the erase/power-down command block
package sfe_pkg;
   localparam logic [7:0] OP_SECTOR_WIPE   = 8'h20;
   localparam logic [7:0] OP_BLOCK32_WIPE  = 8'h52;
   localparam logic [7:0] OP_BLOCK64_WIPE  = 8'hD8;
   localparam logic [7:0] OP_CHIP_WIPE_A   = 8'h60;
   localparam logic [7:0] OP_CHIP_WIPE_B   = 8'hC7;
   localparam logic [7:0] OP_POWER_DOWN    = 8'hB9;
   localparam logic [7:0] OP_WAKE_ID       = 8'hAB;
   localparam logic [7:0] OP_WRITE_UNLOCK  = 8'h06;
   localparam logic [7:0] OP_READ_STATUS   = 8'h05;
   localparam logic [7:0] OP_RESET_ENABLE  = 8'h66;
   localparam logic [7:0] OP_RESET         = 8'h99;
   localparam logic [7:0] DEVICE_ID_RESET  = 8'h5A;
   localparam int unsigned CLK_MHZ         = 50;
   localparam int unsigned SECTOR_WIPE_US  = 100;
   localparam int unsigned BLOCK32_WIPE_US = 150;
   localparam int unsigned BLOCK64_WIPE_US = 200;
   localparam int unsigned CHIP_WIPE_US    = 400;
   localparam int unsigned PD_ENTRY_US     = 3;
   localparam int unsigned WAKE_US         = 3;
   localparam int unsigned WAKE_ID_US      = 5;
   localparam logic [23:0] SECTOR_WIPE_CYC  = 24'(SECTOR_WIPE_US * CLK_MHZ);
   localparam logic [23:0] BLOCK32_WIPE_CYC = 24'(BLOCK32_WIPE_US * CLK_MHZ);
   localparam logic [23:0] BLOCK64_WIPE_CYC = 24'(BLOCK64_WIPE_US * CLK_MHZ);
   localparam logic [23:0] CHIP_WIPE_CYC    = 24'(CHIP_WIPE_US * CLK_MHZ);
   localparam logic [23:0] PD_ENTRY_CYC     = 24'(PD_ENTRY_US * CLK_MHZ);
   localparam logic [23:0] WAKE_CYC         = 24'(WAKE_US * CLK_MHZ);
   localparam logic [23:0] WAKE_ID_CYC      = 24'(WAKE_ID_US * CLK_MHZ);
   localparam logic [7:0]  SCK_HALF_DIV     = 8'h04;
   localparam logic [4:0]  PROT_RESET       = 5'h00;
   localparam logic        INVERT_RESET     = 1'b0;
   localparam logic [31:0] REG_CMD          = 32'h0000_0000;
   localparam logic [31:0] REG_ADDR         = 32'h0000_0004;
   localparam logic [31:0] REG_STATUS       = 32'h0000_0008;
   localparam logic [31:0] REG_RXDATA       = 32'h0000_000C;
   localparam logic [31:0] REG_XFER         = 32'h0000_0010;
   typedef enum logic [1:0] {
      SFE_PWR_STANDBY = 2'b00,
      SFE_PWR_ENTER   = 2'b01,
      SFE_PWR_DEEP    = 2'b10,
      SFE_PWR_WAKING  = 2'b11
   } sfe_pwr_type;
   typedef enum logic [1:0] {
      SFE_H_IDLE = 2'b00,
      SFE_H_SHIFT = 2'b01,
      SFE_H_DESEL = 2'b10
   } sfe_hst_type;
endpackage

// [pkg/sfe_link_if.sv]
// interface: spi link between host controller and flash device
`timescale 1ns/1ps
interface sfe_link_if;
   logic sel_n;
   logic sck;
   logic mosi;
   logic miso;
   logic miso_oe_n;
   modport device (input sel_n, input sck, input mosi, output miso, output miso_oe_n);
   modport host (output sel_n, output sck, output mosi, input miso, input miso_oe_n);
endinterface

// [rtl/sfe_sync.sv]
// two flip-flop synchroniser with clock enable
`timescale 1ns/1ps
module sfe_sync (
   // clock
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic ce,
   // data
   input  wire logic din,
   output logic      dout
);
   typedef struct packed {
      logic m;
      logic s;
   } sfe_sync_type;
   sfe_sync_type r_q;
   sfe_sync_type r_d;
   always_comb begin
      r_d = r_q;
      if (ce) begin
         r_d.m = din;
         r_d.s = r_q.m;
      end
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r_q <= '1; // idle level of select, no false edge after reset
      end else begin
         r_q <= r_d;
      end
   end
   assign dout = r_q.s;
endmodule

// [rtl/sfe_host.sv]
// host end: avalon-mm controlled spi command sender
`timescale 1ns/1ps
module sfe_host
   import sfe_pkg::*;
(
   // clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        ARST_N,
   input  wire logic        CE,
   // avalon-mm slave
   input  wire logic [4:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0]      AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   // link
   sfe_link_if.host         LINK
);
   typedef struct packed {
      sfe_hst_type st;
      logic [7:0]  op;
      logic [23:0] addr;
      logic [5:0]  nbits;
      logic [5:0]  idx;
      logic [39:0] sh;
      logic [7:0]  rx;
      logic [7:0]  div;
      logic        sck;
      logic        sel_n;
      logic [31:0] rdata;
      logic        ack;
   } sfe_hst_reg_type;
   sfe_hst_reg_type r_q;
   sfe_hst_reg_type r_d;
   logic miso_s;
   sfe_sync u_so (.clk(SYS_CLK), .arst_n(ARST_N), .ce(CE), .din(LINK.miso), .dout(miso_s));
   logic [31:0] byte_addr;
   assign byte_addr = {27'h0000000, AVS_ADDRESS};
   always_comb begin
      r_d = r_q;
      r_d.ack = 1'b0;
      if (CE) begin
         if ((AVS_READ || AVS_WRITE) && !r_q.ack) begin
            r_d.ack = 1'b1;
            if (AVS_WRITE) begin
               if (byte_addr == REG_CMD) begin
                  r_d.op = AVS_WRITEDATA[7:0];
               end else if (byte_addr == REG_ADDR) begin
                  r_d.addr = AVS_WRITEDATA[23:0];
               end else if (byte_addr == REG_XFER && r_q.st == SFE_H_IDLE) begin
                  r_d.nbits = AVS_WRITEDATA[5:0];
                  r_d.sh = {r_q.op, r_q.addr, 8'h00};
                  r_d.idx = 6'h00;
                  r_d.st = SFE_H_SHIFT;
                  r_d.sel_n = 1'b0;
                  r_d.div = 8'h00;
               end
            end else begin
               r_d.rdata = 32'h0000_0000;
               if (byte_addr == REG_CMD) begin
                  r_d.rdata = {24'h000000, r_q.op};
               end else if (byte_addr == REG_ADDR) begin
                  r_d.rdata = {8'h00, r_q.addr};
               end else if (byte_addr == REG_STATUS) begin
                  r_d.rdata = {31'h00000000, r_q.st != SFE_H_IDLE};
               end else if (byte_addr == REG_RXDATA) begin
                  r_d.rdata = {24'h000000, r_q.rx};
               end
            end
         end
         unique case (r_q.st)
            SFE_H_IDLE: begin
            end
            SFE_H_SHIFT: begin
               r_d.div = r_q.div + 8'h01;
               if (r_q.div == SCK_HALF_DIV) begin
                  r_d.div = 8'h00;
                  if (!r_q.sck) begin
                     if (r_q.idx == r_q.nbits) begin
                        r_d.st = SFE_H_DESEL;
                        r_d.sel_n = 1'b1;
                     end else begin
                        r_d.sck = 1'b1;
                        r_d.idx = r_q.idx + 6'h01;
                     end
                  end else begin
                     // synced output of the last device fall is settled here
                     r_d.rx = {r_q.rx[6:0], miso_s};
                     r_d.sck = 1'b0;
                     r_d.sh = {r_q.sh[38:0], 1'b0};
                  end
               end
            end
            SFE_H_DESEL: begin
               r_d.div = r_q.div + 8'h01;
               if (r_q.div == SCK_HALF_DIV) begin
                  r_d.st = SFE_H_IDLE;
               end
            end
            default: begin
               r_d.st = SFE_H_IDLE;
            end
         endcase
      end
   end
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         r_q <= '0;
         r_q.sel_n <= 1'b1;
      end else begin
         r_q <= r_d;
      end
   end
   assign LINK.sel_n = r_q.sel_n;
   assign LINK.sck = r_q.sck;
   assign LINK.mosi = r_q.sh[39];
   assign AVS_READDATA = r_q.rdata;
   assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !r_q.ack;
endmodule

// [testbench/sfe_link_chk.sv]
// checker: link and device state relations of the erase/power-down block
`timescale 1ns/1ps
module sfe_link_chk (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic ARST_N,
   // link
   input wire logic sel_n,
   input wire logic sck,
   input wire logic miso,
   input wire logic miso_oe_n,
   // device state
   input wire logic BUSY,
   input wire logic WRITE_LATCH,
   input wire logic DEEP_POWER,
   input wire logic WIPE_STROBE
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!ARST_N);
   a_start_after_sel: assert property (WIPE_STROBE |-> sel_n && $past(sel_n))
      else $error("wipe started while selected");
   a_strobe_sets_busy: assert property (WIPE_STROBE |-> ##[0:1] BUSY)
      else $error("busy not raised at wipe start");
   a_no_wipe_busy: assert property ($past(BUSY) |-> !WIPE_STROBE)
      else $error("wipe started during running cycle");
   a_wipe_needs_latch: assert property (WIPE_STROBE |-> WRITE_LATCH || $past(WRITE_LATCH))
      else $error("wipe started without write latch");
   a_latch_gone_end: assert property ($fell(BUSY) |-> !WRITE_LATCH)
      else $error("write latch still set after wipe");
   a_deep_not_busy: assert property ($rose(DEEP_POWER) |-> !BUSY)
      else $error("deep power entered during cycle");
   a_deep_no_wipe: assert property (DEEP_POWER |-> !WIPE_STROBE)
      else $error("wipe started in deep power");
   a_deep_deselected: assert property ($rose(DEEP_POWER) |-> sel_n && $past(sel_n, 2))
      else $error("deep power entered while selected");
   a_reset_standby: assert property ($rose(ARST_N) |-> !DEEP_POWER && !BUSY)
      else $error("not standby after reset");
   a_idle_released: assert property (sel_n [*6] |-> miso_oe_n)
      else $error("output driven while deselected");
   a_miso_on_fall: assert property (!miso_oe_n && $changed(miso) |-> !sck)
      else $error("output changed while clock high");
endmodule

// [testbench/sfe_test.sv]
// testbench: host and device ends joined over the link, driven over avalon
`timescale 1ns/1ps
module sfe_test;
   import sfe_pkg::*;
   logic        sys_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [4:0]  avs_address = 5'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [4:0]  prot_range = 5'h00;
   logic        prot_invert = 1'b0;
   logic        busy, write_latch, deep_power, wipe_strobe;
   logic [23:0] wipe_addr;
   logic [1:0]  wipe_kind;
   logic [31:0] rd;
   int          miscompares = 0;
   int          num_checks = 0;
   int          strobes = 0;
   localparam logic [7:0] ID_VALUE = 8'hA5; // arbitrary value
   sfe_link_if link ();
   always #10 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (wipe_strobe === 1'b1) strobes <= strobes + 1;
   sfe_device u_sfe_device (.SYS_CLK(sys_clk), .ARST_N(arst_n), .CE(1'b1), .LINK(link.device),
      .PROT_RANGE(prot_range), .PROT_INVERT(prot_invert), .DEVICE_ID(ID_VALUE),
      .BUSY(busy), .WRITE_LATCH(write_latch), .DEEP_POWER(deep_power),
      .WIPE_STROBE(wipe_strobe), .WIPE_ADDR(wipe_addr), .WIPE_KIND(wipe_kind));
   sfe_host u_sfe_host (.SYS_CLK(sys_clk), .ARST_N(arst_n), .CE(1'b1),
      .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
      .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
      .AVS_WAITREQUEST(avs_waitrequest), .LINK(link.host));
   sfe_link_chk u_sfe_link_chk (.SYS_CLK(sys_clk), .ARST_N(arst_n), .sel_n(link.sel_n),
      .sck(link.sck), .miso(link.miso), .miso_oe_n(link.miso_oe_n), .BUSY(busy),
      .WRITE_LATCH(write_latch), .DEEP_POWER(deep_power), .WIPE_STROBE(wipe_strobe));
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic give_up(input string what);
      miscompares++;
      $display("mismatch %s expected done seen timeout", what);
      close_out();
   endtask
   // one avalon cycle, held until waitrequest is sampled low at a rising edge
   task automatic av_xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      avs_address <= a[4:0];
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      do begin
         @(posedge sys_clk);
         n++;
         if (n > 50) give_up("waitrequest");
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   // one framed command of nb link clocks
   task automatic spi(input logic [7:0] op, input logic [23:0] adr, input int nb);
      int n;
      n = 0;
      av_xfer(1'b1, REG_CMD, {24'h0, op});
      av_xfer(1'b1, REG_ADDR, {8'h0, adr});
      av_xfer(1'b1, REG_XFER, 32'(nb));
      do begin
         av_xfer(1'b0, REG_STATUS, 32'h0);
         n++;
         if (n > 400) give_up("transfer");
      end while (rd[0] !== 1'b0);
      repeat (10) @(posedge sys_clk);
   endtask
   task automatic wait_idle();
      int n;
      for (n = 0; busy !== 1'b0; n++) begin
         if (n > 25000) give_up("busy");
         @(posedge sys_clk);
      end
   endtask
   task automatic t_after_reset();
      check("busy", 32'h0, 32'(busy));
      check("deep", 32'h0, 32'(deep_power));
      check("latch", 32'h0, 32'(write_latch));
      $display("test after_reset done");
   endtask
   task automatic t_wipes();
      logic [7:0]  ops [5] = '{OP_SECTOR_WIPE, OP_BLOCK32_WIPE, OP_BLOCK64_WIPE,
                               OP_CHIP_WIPE_A, OP_CHIP_WIPE_B};
      logic [23:0] adrs [5] = '{24'h012345, 24'h03ABCD, 24'h05FFFF, 24'h0, 24'h0};
      logic [23:0] base [5] = '{24'h012000, 24'h038000, 24'h050000, 24'h0, 24'h0};
      int s;
      for (int i = 0; i < 5; i++) begin
         prot_range <= (i == 4) ? 5'h07 : 5'h00;
         prot_invert <= (i == 4);
         spi(OP_WRITE_UNLOCK, 24'h0, 8);
         check("latch", 32'h1, 32'(write_latch));
         s = strobes;
         spi(ops[i], adrs[i], (i > 2) ? 8 : 32);
         check("strobes", 32'(s + 1), 32'(strobes));
         check("kind", 32'((i < 3) ? i : 3), 32'(wipe_kind));
         if (i < 3) check("addr", 32'(base[i]), 32'(wipe_addr));
         spi(OP_READ_STATUS, 24'h0, 16);
         av_xfer(1'b0, REG_RXDATA, 32'h0);
         check("status busy", 32'h1, 32'(rd[0]));
         check("status latch", 32'h1, 32'(rd[1]));
         wait_idle();
         check("latch", 32'h0, 32'(write_latch));
      end
      prot_range <= 5'h00;
      prot_invert <= 1'b0;
      $display("test wipes done");
   endtask
   task automatic t_refused();
      int s;
      s = strobes;
      spi(OP_SECTOR_WIPE, 24'h001000, 32);
      spi(OP_WRITE_UNLOCK, 24'h0, 8);
      spi(OP_SECTOR_WIPE, 24'h001000, 24);
      spi(OP_BLOCK64_WIPE, 24'h001000, 40);
      spi(OP_CHIP_WIPE_A, 24'h0, 16);
      spi(OP_POWER_DOWN, 24'h0, 16);
      prot_range <= 5'h01;
      spi(OP_CHIP_WIPE_B, 24'h0, 8);
      prot_invert <= 1'b1;
      spi(OP_SECTOR_WIPE, 24'h001000, 32);
      prot_range <= 5'h00;
      prot_invert <= 1'b0;
      check("strobes", 32'(s), 32'(strobes));
      repeat (PD_ENTRY_CYC + 20) @(posedge sys_clk);
      check("deep", 32'h0, 32'(deep_power));
      $display("test refused done");
   endtask
   task automatic t_deep();
      spi(OP_WRITE_UNLOCK, 24'h0, 8);
      spi(OP_SECTOR_WIPE, 24'h002000, 32);
      spi(OP_POWER_DOWN, 24'h0, 8);
      spi(OP_WAKE_ID, 24'h0, 40);
      repeat (PD_ENTRY_CYC + 20) @(posedge sys_clk);
      check("deep", 32'h0, 32'(deep_power));
      check("busy", 32'h1, 32'(busy));
      wait_idle();
      spi(OP_POWER_DOWN, 24'h0, 8);
      repeat (PD_ENTRY_CYC + 20) @(posedge sys_clk);
      check("deep", 32'h1, 32'(deep_power));
      spi(OP_WRITE_UNLOCK, 24'h0, 8);
      check("latch", 32'h0, 32'(write_latch));
      spi(OP_WAKE_ID, 24'h0, 8);
      repeat (WAKE_CYC + 20) @(posedge sys_clk);
      check("deep", 32'h0, 32'(deep_power));
      spi(OP_POWER_DOWN, 24'h0, 8);
      repeat (PD_ENTRY_CYC + 20) @(posedge sys_clk);
      check("deep", 32'h1, 32'(deep_power));
      spi(OP_RESET_ENABLE, 24'h0, 8);
      spi(OP_RESET, 24'h0, 8);
      repeat (WAKE_CYC + 20) @(posedge sys_clk);
      check("deep", 32'h0, 32'(deep_power));
      spi(OP_WAKE_ID, 24'h0, 40);
      av_xfer(1'b0, REG_RXDATA, 32'h0);
      check("id", 32'(ID_VALUE), {24'h0, rd[7:0]});
      repeat (WAKE_ID_CYC + 20) @(posedge sys_clk);
      spi(OP_WAKE_ID, 24'h0, 48);
      av_xfer(1'b0, REG_RXDATA, 32'h0);
      check("id repeat", 32'(ID_VALUE), {24'h0, rd[7:0]});
      spi(OP_POWER_DOWN, 24'h0, 8);
      repeat (PD_ENTRY_CYC + 20) @(posedge sys_clk);
      check("deep", 32'h1, 32'(deep_power));
      arst_n <= 1'b0;
      repeat (20) @(posedge sys_clk);
      arst_n <= 1'b1;
      check("deep", 32'h0, 32'(deep_power));
      spi(OP_WRITE_UNLOCK, 24'h0, 8);
      check("latch", 32'h1, 32'(write_latch));
      $display("test deep done");
   endtask
   initial begin
      repeat (20) @(posedge sys_clk);
      arst_n <= 1'b1;
      t_after_reset();
      t_wipes();
      t_refused();
      t_deep();
      close_out();
   end
endmodule
